// ==== gamma_dac_i2c_slave_params.svh ====
/*
  constants of the two-wire gamma and common-voltage reference slave:
  pointer map, command codes, reset codes and input filter timing.
  assumes it is included by bare name from the package and the bench.
*/

`ifndef GAMMA_DAC_I2C_SLAVE_PARAMS_SVH
`define GAMMA_DAC_I2C_SLAVE_PARAMS_SVH

// ------------------------------------------------------------
// channel map
// ------------------------------------------------------------
`define GD_NUM_CHAN      18
`define GD_CODE_W        10
`define GD_PTR_GAMMA_END 6'h0F
`define GD_PTR_COMMON_VOLTAGE_CHANNEL_1     6'h12
`define GD_PTR_COMMON_VOLTAGE_CHANNEL_2     6'h13
`define GD_PTR_LAST_ACK  6'h17
`define GD_PTR_DEV_ID    6'h3D
`define GD_IDX_COMMON_VOLTAGE_CHANNEL_1     5'h10
`define GD_IDX_COMMON_VOLTAGE_CHANNEL_2     5'h11

// ------------------------------------------------------------
// codes and reset values
// ------------------------------------------------------------
`define GD_MID_SCALE     10'h200
`define GD_GC_ADDR       8'h00
`define GD_GC_RESET      8'h06
`define GD_HS_CODE       5'h01
`define GD_TGT_NV        2'h1
`define GD_BYTE_BITS     4'h8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GD_CLK_PERIOD_NS 5
`define GD_FILT_FS_NS    20
`define GD_FILT_HS_NS    10

`endif

// ==== gamma_dac_i2c_slave_pkg.sv ====
/*
  types of the two-wire gamma reference slave: state enum and the
  packed register image of the whole block.
  assumes the params header is on the include path.
*/
package gamma_dac_i2c_slave_pkg;
`include "gamma_dac_i2c_slave_params.svh"

  // protocol states
  typedef enum logic [3:0] {
    st_load, st_idle, st_wait, st_addr, st_ptr, st_wmsb, st_wlsb,
    st_gcdata, st_ack, st_rd, st_rack
  } state_t;

  // full register image, one always_ff
  typedef struct packed {
    logic [1:0]                                  sync1;
    logic [1:0]                                  sync2;
    logic [1:0]                                  filt;
    logic [1:0]                                  filt_d;
    logic [1:0][2:0]                             cnt;
    state_t                                      state;
    state_t                                      after_ack;
    logic [3:0]                                  bitcnt;
    logic [7:0]                                  shreg;
    logic [7:0]                                  msb;
    logic [7:0]                                  tx;
    logic                                        hs;
    logic                                        oe;
    logic                                        lsb_phase;
    logic                                        mack;
    logic                                        gc_reset;
    logic [5:0]                                  ptr;
    logic [`GD_NUM_CHAN-1:0][`GD_CODE_W-1:0]     hold;
    logic [`GD_NUM_CHAN-1:0][`GD_CODE_W-1:0]     dac;
    logic                                        nv_wr;
    logic [4:0]                                  nv_idx;
    logic [`GD_CODE_W-1:0]                       nv_data;
  } regs_t;

endpackage

// ==== gamma_dac_i2c_slave.sv ====
/*
  two-wire slave front end of the gamma and common-voltage reference:
  holding and output code registers, double-buffered update, general
  call reset, high-speed master code and nonvolatile write requests.
  assumes scl_in/sda_in are the resolved open-drain wire levels from
  another domain, and nv_code_in/nv_programmed_in are static values
  of the nonvolatile store on the clk_in domain.
*/
`timescale 1ns/1ps

module gamma_dac_i2c_slave
  import gamma_dac_i2c_slave_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR = 7'h74,   // bus address, plain default
  parameter logic [15:0] DEVICE_ID  = 16'h1234 // identity word, arbitrary value
) (
  // clock and reset
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_in,
  // two-wire bus pins
  input  wire logic                                   scl_in,
  input  wire logic                                   sda_in,
  output wire logic                                   sda_out,
  output wire logic                                   sda_oe_out,
  // nonvolatile store contents
  input  wire logic [`GD_NUM_CHAN-1:0][`GD_CODE_W-1:0] nv_code_in,
  input  wire logic [`GD_NUM_CHAN-1:0]                nv_programmed_in,
  // channel output codes and mode
  output wire logic [`GD_NUM_CHAN-1:0][`GD_CODE_W-1:0] dac_code_out,
  output wire logic                                   hs_mode_out,
  // nonvolatile write request
  output wire logic                                   nv_write_out,
  output wire logic [4:0]                             nv_index_out,
  output wire logic [`GD_CODE_W-1:0]                  nv_data_out
);

  // ------------------------------------------------------------
  // constants and state
  // ------------------------------------------------------------
  localparam logic [2:0] FILT_FS = 3'((`GD_FILT_FS_NS) / (`GD_CLK_PERIOD_NS));
  localparam logic [2:0] FILT_HS = 3'((`GD_FILT_HS_NS) / (`GD_CLK_PERIOD_NS));

  regs_t q;        // registered image
  regs_t n;        // next image
  logic  scl_rise; // filtered clock rose
  logic  scl_fall; // filtered clock fell
  logic  start_ev; // data fell, clock high
  logic  stop_ev;  // data rose, clock high
  logic  word_done; // second data byte just accepted

  // ------------------------------------------------------------
  // decoding functions
  // ------------------------------------------------------------
  // pointer to channel index, msb is the valid flag
  function automatic logic [5:0] chan_of(input logic [5:0] p);
    if (p <= `GD_PTR_GAMMA_END) begin
      return {1'b1, 1'b0, p[3:0]};
    end else if (p == `GD_PTR_COMMON_VOLTAGE_CHANNEL_1) begin
      return {1'b1, `GD_IDX_COMMON_VOLTAGE_CHANNEL_1};
    end else if (p == `GD_PTR_COMMON_VOLTAGE_CHANNEL_2) begin
      return {1'b1, `GD_IDX_COMMON_VOLTAGE_CHANNEL_2};
    end
    return 6'h00;
  endfunction

  // word returned by a read of pointer p
  function automatic logic [15:0] read_word(
    input logic [5:0]                              p,
    input logic [`GD_NUM_CHAN-1:0][`GD_CODE_W-1:0] h
  );
    logic [5:0] c;
    c = chan_of(p);
    if (p == `GD_PTR_DEV_ID) begin
      return DEVICE_ID;
    end
    if (c[5]) begin
      return {6'h00, h[c[4:0]]};
    end
    return 16'h0000;
  endfunction

  // ------------------------------------------------------------
  // line events from the filtered levels
  // ------------------------------------------------------------
  // bit 1 is the clock line, bit 0 the data line
  assign scl_rise = q.filt[1] & ~q.filt_d[1];
  assign scl_fall = ~q.filt[1] & q.filt_d[1];
  // data edge with clock high is a condition
  assign start_ev = q.filt[1] & q.filt_d[1] & ~q.filt[0] & q.filt_d[0];
  assign stop_ev  = q.filt[1] & q.filt_d[1] & q.filt[0] & ~q.filt_d[0];
  assign word_done = (q.state == st_wlsb) && scl_fall && (q.bitcnt == `GD_BYTE_BITS);

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic        ack;    // acknowledge the finished byte
    logic [5:0]  ci;     // channel decode
    logic [15:0] word;   // assembled or read word
    logic [7:0]  nbyte;  // next byte to transmit
    ack   = 1'b0;
    ci    = 6'h00;
    word  = 16'h0000;
    nbyte = 8'h00;
    n     = q;
    n.nv_wr = 1'b0;

    n.sync1  = {scl_in, sda_in};
    n.sync2  = q.sync1;
    n.filt_d = q.filt;
    // standard and fast filter by default
    for (int i = 0; i < 2; i++) begin
      if (q.sync2[i] == q.filt[i]) begin
        n.cnt[i] = 3'h0;
      end else if (q.cnt[i] >= (q.hs ? FILT_HS : FILT_FS) - 3'h1) begin
        // shorter filter while in high-speed mode
        n.filt[i] = q.sync2[i];
        n.cnt[i]  = 3'h0;
      end else begin
        n.cnt[i] = q.cnt[i] + 3'h1;
      end
    end

    if (q.state != st_load && stop_ev) begin
      n.state    = st_idle;
      n.oe       = 1'b0;
      n.hs       = 1'b0;
      n.gc_reset = 1'b0; // a cut reset command is dropped
    end else if (q.state != st_load && start_ev) begin
      // restart abandons a half word, hs kept
      n.state    = st_addr;
      n.bitcnt   = 4'h0;
      n.oe       = 1'b0;
      n.gc_reset = 1'b0; // a cut reset command is dropped
    end else begin
      unique case (q.state)
        st_load: begin
          for (int c = 0; c < `GD_NUM_CHAN; c++) begin
            n.hold[c] = nv_programmed_in[c] ? nv_code_in[c] : `GD_MID_SCALE;
            n.dac[c]  = nv_programmed_in[c] ? nv_code_in[c] : `GD_MID_SCALE;
          end
          n.hs        = 1'b0;
          n.oe        = 1'b0;
          n.ptr       = 6'h00;
          n.gc_reset  = 1'b0;
          n.state     = st_idle;
        end
        // waiting for a start or stop
        st_idle, st_wait: begin
        end
        // receiving a byte
        st_addr, st_ptr, st_wmsb, st_wlsb, st_gcdata: begin
          if (scl_rise) begin
            n.shreg  = {q.shreg[6:0], q.filt[0]};
            n.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == `GD_BYTE_BITS) begin
            n.bitcnt = 4'h0;
            if (q.state == st_addr) begin
              if (q.shreg[7:3] == `GD_HS_CODE) begin
                n.hs = 1'b1;
              end else if (q.shreg == `GD_GC_ADDR) begin
                ack         = 1'b1;
                n.after_ack = st_gcdata;
              end else if (q.shreg[7:1] == SLAVE_ADDR) begin
                // last bit chooses read or write
                ack         = 1'b1;
                n.after_ack = q.shreg[0] ? st_rd : st_ptr;
              end
            end else if (q.state == st_ptr) begin
              // pointer acked up to the last slot and at the identity word
              if (q.shreg[7:6] == 2'h0 &&
                  (q.shreg[5:0] <= `GD_PTR_LAST_ACK ||
                   q.shreg[5:0] == `GD_PTR_DEV_ID)) begin
                ack         = 1'b1;
                n.ptr       = q.shreg[5:0];
                n.after_ack = st_wmsb;
              end
            end else if (q.state == st_wmsb) begin
              // high byte held until low byte
              ack         = 1'b1;
              n.msb       = q.shreg;
              n.after_ack = st_wlsb;
            end else if (q.state == st_wlsb) begin
              word = {q.msb, q.shreg};
              ci   = chan_of(q.ptr);
              ack  = 1'b1;
              if (ci[5]) begin
                n.hold[ci[4:0]] = word[`GD_CODE_W-1:0];
                // top bits 01 program nonvolatile store
                if (word[15:14] == `GD_TGT_NV) begin
                  n.dac[ci[4:0]] = word[`GD_CODE_W-1:0];
                  n.nv_wr        = 1'b1;
                  n.nv_idx       = ci[4:0];
                  n.nv_data      = word[`GD_CODE_W-1:0];
                end
              end
              // bit 15 moves every holding code out
              if (word[15]) begin
                n.dac = n.hold;
              end
              n.ptr       = q.ptr + 6'h01;
              n.after_ack = st_wmsb;
            end else begin
              if (q.shreg == `GD_GC_RESET) begin
                ack        = 1'b1;
                n.gc_reset = 1'b1;
                n.after_ack = st_wait;
              end
            end
            // pull data low for the ninth pulse
            n.oe    = ack;
            n.state = ack ? st_ack : st_wait;
          end
        end
        // acknowledge pulse, released at its falling clock
        st_ack: begin
          if (scl_fall) begin
            n.oe     = 1'b0;
            n.bitcnt = 4'h0;
            n.state  = q.gc_reset ? st_load : q.after_ack;
            if (q.after_ack == st_rd && !q.gc_reset) begin
              word        = read_word(q.ptr, q.hold);
              n.oe        = ~word[15];
              n.tx        = {word[14:8], 1'b0};
              n.bitcnt    = 4'h1;
              n.lsb_phase = 1'b0;
            end
          end
        end
        // transmitting, each bit set just after a falling clock
        st_rd: begin
          if (scl_fall) begin
            if (q.bitcnt == `GD_BYTE_BITS) begin
              n.oe    = 1'b0;
              n.state = st_rack;
            end else begin
              // data changes only with clock low
              n.oe     = ~q.tx[7];
              n.tx     = {q.tx[6:0], 1'b0};
              n.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        // master acknowledge of a transmitted byte
        st_rack: begin
          if (scl_rise) begin
            n.mack = ~q.filt[0];
          end else if (scl_fall) begin
            if (q.mack) begin
              if (!q.lsb_phase) begin
                // low byte follows the high byte
                word        = read_word(q.ptr, q.hold);
                nbyte       = word[7:0];
                n.lsb_phase = 1'b1;
              end else begin
                // read pointer steps after each word
                n.ptr       = q.ptr + 6'h01;
                word        = read_word(q.ptr + 6'h01, q.hold);
                nbyte       = word[15:8];
                n.lsb_phase = 1'b0;
              end
              n.oe     = ~nbyte[7];
              n.tx     = {nbyte[6:0], 1'b0};
              n.bitcnt = 4'h1;
              n.state  = st_rd;
            end else begin
              n.state = st_wait;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q           <= '0;
      q.sync1     <= 2'h3;
      q.sync2     <= 2'h3;
      q.filt      <= 2'h3;
      q.filt_d    <= 2'h3;
      q.state     <= st_load;
      q.after_ack <= st_idle;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // only the data line has a driver, never the clock
  assign sda_out      = 1'b0;
  assign sda_oe_out   = q.oe;
  assign dac_code_out = q.dac;
  assign hs_mode_out  = q.hs;
  assign nv_write_out = q.nv_wr;
  assign nv_index_out = q.nv_idx;
  assign nv_data_out  = q.nv_data;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_ack_address: assert property (
    (q.state == st_addr && scl_fall && q.bitcnt == `GD_BYTE_BITS
     && q.shreg[7:1] == SLAVE_ADDR) |=> sda_oe_out && q.state == st_ack)
    else $error("matched address not acknowledged");

  chk_drive_scl_low: assert property (
    $rose(sda_oe_out) |-> !q.filt[1])
    else $error("data driven low while clock high");

  chk_hs_no_ack: assert property (
    (q.state == st_addr && scl_fall && q.bitcnt == `GD_BYTE_BITS
     && q.shreg[7:3] == `GD_HS_CODE) |=> hs_mode_out && !sda_oe_out)
    else $error("master code acked or mode not entered");

  chk_hs_stop_exit: assert property (
    (stop_ev && q.state != st_load) |=> !hs_mode_out && q.state == st_idle)
    else $error("high-speed mode kept after stop");

  chk_gc_bad_nack: assert property (
    (q.state == st_gcdata && scl_fall && q.bitcnt == `GD_BYTE_BITS
     && q.shreg != `GD_GC_RESET) |=> !sda_oe_out ##1 !q.gc_reset)
    else $error("general call data other than reset acked");

  chk_gc_reload: assert property (
    (q.state == st_ack && q.gc_reset && scl_fall) |=> q.state == st_load
      ##1 (q.state == st_idle && !hs_mode_out))
    else $error("general call reset did not reload");

  chk_sync_update: assert property (
    (word_done && q.msb[7]) |=> dac_code_out == q.hold)
    else $error("outputs not updated by bit 15");

  chk_hold_only: assert property (
    (word_done && !q.msb[7] && q.msb[7:6] != `GD_TGT_NV) |=> $stable(dac_code_out))
    else $error("outputs moved without bit 15");

  chk_ptr_advance: assert property (
    word_done |=> q.ptr == $past(q.ptr) + 6'h01)
    else $error("pointer did not advance after word");

  chk_nv_request: assert property (
    (word_done && q.msb[7:6] == `GD_TGT_NV && chan_of(q.ptr) != 6'h00)
      |=> nv_write_out ##1 !nv_write_out)
    else $error("nonvolatile request missing or too long");

endmodule // gamma_dac_i2c_slave

// ==== master_model.sv ====
/*
  two-wire bus master model: drives the bus clock and pulls the data
  line low, samples the resolved data wire at the end of each high phase.
  assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps

module master_model (
  // clock
  input  wire logic clk_in,
  // bus lines
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // bus idles released, clock high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // wait whole system clock cycles
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic bit_io(input logic b, output logic seen);
    sda_low_out <= ~b;
    wt(4);
    scl_out <= 1'b1;
    wt(5);
    @(negedge clk_in);
    seen = sda_wire_in;
    wt(1);
    scl_out <= 1'b0;
    wt(8);
  endtask

  // start, repeated when the clock is low
  task automatic start();
    if (scl_out === 1'b0) begin
      sda_low_out <= 1'b0;
      wt(4);
      scl_out <= 1'b1;
      wt(8);
    end
    sda_low_out <= 1'b1;
    wt(8);
    scl_out <= 1'b0;
    wt(8);
  endtask

  // stop, data rises with clock high
  task automatic stop();
    sda_low_out <= 1'b1;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    sda_low_out <= 1'b0;
    wt(12);
  endtask

  // byte sent msb first, ninth bit released
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // read one byte, then ack or nack it
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule // master_model

// ==== gamma_dac_i2c_slave_test.sv ====
/*
  bench of the gamma reference two-wire slave: codes, acks, reads.
  assumes the package, its header and the master model compile first.
*/
`timescale 1ns/1ps
`include "gamma_dac_i2c_slave_params.svh"

module gamma_dac_i2c_slave_test;
  localparam logic [6:0]  ADDR = 7'h74;    // bus address
  localparam logic [15:0] ID   = 16'h5A3C; // identity word, arbitrary value
  logic clk_in, rst_in, scl, m_low, sda_oe_out, sda_out, hs_mode_out, nv_write_out;
  wire  sda_wire;                                 // resolved data wire
  logic [`GD_NUM_CHAN-1:0][`GD_CODE_W-1:0] nv_code, dac_code_out;
  logic [`GD_NUM_CHAN-1:0]                nv_prog;
  logic [4:0]  nv_index_out, nv_idx;              // request index, captured
  logic [9:0]  nv_data_out, nv_dat;               // request code, captured
  logic [9:0]  exp_dac [`GD_NUM_CHAN];            // expected output codes
  int          n_errors, total_checks, nv_count;

  // open-drain wire with pull-up
  assign sda_wire = ~m_low & ~(sda_oe_out & ~sda_out);
  always #2.5 clk_in = ~clk_in;

  gamma_dac_i2c_slave #(.SLAVE_ADDR(ADDR), .DEVICE_ID(ID)) i_gamma_dac_i2c_slave (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .nv_code_in(nv_code),
    .nv_programmed_in(nv_prog), .dac_code_out(dac_code_out),
    .hs_mode_out(hs_mode_out), .nv_write_out(nv_write_out),
    .nv_index_out(nv_index_out), .nv_data_out(nv_data_out));
  master_model i_master_model (
    .clk_in(clk_in), .sda_wire_in(sda_wire), .scl_out(scl), .sda_low_out(m_low));

  // capture nonvolatile write pulses away from the edge
  always @(negedge clk_in) begin
    if (nv_write_out === 1'b1) begin
      nv_count++;
      nv_idx = nv_index_out;
      nv_dat = nv_data_out;
    end
  end

  function automatic logic [9:0] pcode(input int k);
    return nv_prog[k] ? nv_code[k] : `GD_MID_SCALE;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_outputs();
    for (int k = 0; k < `GD_NUM_CHAN; k++) begin
      chk("output code", {6'h00, exp_dac[k]}, {6'h00, dac_code_out[k]});
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic ack;
    i_master_model.wbyte(b, ack);
    chk("ack", {15'h0, exp_ack}, {15'h0, ack});
  endtask

  task automatic wr_words(input logic [7:0] ptr, input logic [15:0] w[$]);
    i_master_model.start();
    put({ADDR, 1'b0}, 1'b1);
    put(ptr, 1'b1);
    foreach (w[i]) begin
      put(w[i][15:8], 1'b1);
      put(w[i][7:0], 1'b1);
    end
    i_master_model.stop();
  endtask

  task automatic rd_check(input logic [7:0] ptr, input logic [15:0] exp);
    logic [7:0] hi, lo;
    i_master_model.start();
    put({ADDR, 1'b0}, 1'b1);
    put(ptr, 1'b1);
    i_master_model.start();
    put({ADDR, 1'b1}, 1'b1);
    i_master_model.rbyte(1'b1, hi);
    i_master_model.rbyte(1'b0, lo);
    i_master_model.stop();
    chk("read word", exp, {hi, lo});
  endtask

  task automatic t_double_buffer();
    wr_words(8'h12, '{16'h0155});
    chk_outputs();
    wr_words(8'h0E, '{16'h0011, 16'h0022, 16'h0333, 16'h0344, 16'h8123});
    exp_dac[14] = 10'h011;
    exp_dac[15] = 10'h022;
    exp_dac[16] = 10'h123;
    chk_outputs();
    rd_check(8'h0F, 16'h0022);
    rd_check(8'h10, 16'h0000);
    rd_check(8'h3D, ID);
  endtask

  task automatic t_half_word_and_refuse();
    i_master_model.start();
    put({ADDR, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    put(8'h83, 1'b1);
    i_master_model.stop();
    chk_outputs();
    rd_check(8'h00, {6'h00, pcode(0)});
    i_master_model.start();
    put({ADDR ^ 7'h01, 1'b0}, 1'b0);
    i_master_model.stop();
    i_master_model.start();
    put({ADDR, 1'b0}, 1'b1);
    put(8'h18, 1'b0);
    i_master_model.stop();
  endtask

  task automatic t_nv_write();
    wr_words(8'h03, '{16'h4155});
    exp_dac[3] = 10'h155;
    chk("nv pulses", 16'h0001, nv_count[15:0]);
    chk("nv index", 16'h0003, {11'h0, nv_idx});
    chk("nv data", 16'h0155, {6'h00, nv_dat});
    chk_outputs();
  endtask

  task automatic t_general_call();
    i_master_model.start();
    put(8'h00, 1'b1);
    put(8'h07, 1'b0);
    i_master_model.stop();
    chk_outputs();
    i_master_model.start();
    put(8'h00, 1'b1);
    put(8'h06, 1'b1);
    i_master_model.stop();
    for (int k = 0; k < `GD_NUM_CHAN; k++) begin
      exp_dac[k] = pcode(k);
    end
    chk_outputs();
  endtask

  task automatic t_high_speed();
    for (int x = 0; x < 8; x++) begin
      i_master_model.start();
      put({5'h01, x[2:0]}, 1'b0);
      chk("hs after code", 16'h0001, {15'h0, hs_mode_out});
      i_master_model.start();
      put({ADDR, 1'b0}, 1'b1);
      chk("hs after restart", 16'h0001, {15'h0, hs_mode_out});
      i_master_model.stop();
      chk("hs after stop", 16'h0000, {15'h0, hs_mode_out});
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog on a hung bus sequence
  initial begin
    repeat (80000) @(posedge clk_in);
    n_errors++;
    give_verdict();
  end

  // main sequence
  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    for (int k = 0; k < `GD_NUM_CHAN; k++) begin
      nv_code[k] = 10'h100 + 10'(k);
      nv_prog[k] = ~k[0];
      exp_dac[k] = pcode(k);
    end
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    chk_outputs();
    t_double_buffer();
    t_half_word_and_refuse();
    t_nv_write();
    t_general_call();
    t_high_speed();
    give_verdict();
  end
endmodule // gamma_dac_i2c_slave_test
